// [mcr_clock_ctrl.sv]
// module: main clock controller with timebase counter, clock out and beeper
//
// The Wishbone slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module mcr_clock_ctrl (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core power-mode handshake
  input wire logic halt_req_i,
  input wire logic wake_i,
  output logic [1:0] power_mode_o,
  output logic wake_o,
  // clocks and pins
  output logic core_clk_en_o,
  output logic clock_out_pin_o,
  output logic clock_out_oe_o,
  output logic tone_pin_o,
  output logic tone_oe_o,
  output logic irq_o
);
  mcr_pkg::mcr_wb_req_t req;
  mcr_pkg::mcr_mode_t mode_reg;
  logic [7:0] ctrl_reg;
  // writable control bits 7..1 and the hardware-set flag live in
  // separate registers so that each has a single clocked driver
  logic [7:1] ctrl_bits_reg;
  logic ovf_flag_reg;
  logic [1:0] tone_sel_reg;
  logic irq_status_reg;
  logic irq_enable_reg;
  logic [17:0] tb_count_reg;
  logic [1:0] tb_active_reg;
  logic [17:0] tb_period;
  logic tb_wrap;
  logic [3:0] div_count_reg;
  logic core_en_reg;
  logic core_en_next;
  logic clk_out_reg;
  logic [13:0] tone_count_reg;
  logic [13:0] tone_half;
  logic tone_reg;
  logic access;
  logic wr;
  logic rd;
  logic frozen;
  logic counting;
  logic ovf_req;

  // register map on the byte address, all registers in bits 7:0:
  //   0x00 control/status: clock-out, prescaler, slow mode, timebase,
  //        overflow enable and overflow flag (read clears the flag)
  //   0x04 tone select, two bits
  //   0x08 sticky interrupt status, read only
  //   0x0C interrupt clear, write one to bit 0
  //   0x10 interrupt enable, bit 0
  //   0x14 power mode: reads the mode, writing bit 0 enters wait
  // unmapped reads return zero and unmapped writes are dropped,
  // both still acknowledged so a stray access never hangs the bus
  //
  // timing, all in oscillator cycles on clk_i:
  //   the bus answers exactly one cycle after the take
  //   the overflow flag rises as the counter wraps to zero, one period after its last wrap
  //   slow mode enables the core once every 2, 4, 8 or 16 cycles
  //   the tone pin toggles every half period of the selected tone
  //
  // limitation: the clock-out pin carries the core clock halved by the
  // toggle, so in normal mode it runs at half the oscillator rate

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                 sel: wb_sel_i, dat: wb_dat_i};
  // single-cycle ack; new request only after ack drops
  assign access = req.cyc && req.stb && !wb_ack_o;
  assign wr = access && req.we && req.sel[0];
  assign rd = access && !req.we;
  // control/status and tone select ignore writes in either halt flavour
  // registers frozen
  assign frozen = (mode_reg == mcr_pkg::MODE_ACTIVE_HALT) || (mode_reg == mcr_pkg::MODE_HALT);
  assign counting = (mode_reg != mcr_pkg::MODE_HALT);

  // a request is taken only while ack is low, so a master that holds
  // its request through the ack cycle is never answered twice
  // bus ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= access;
  end

  // read data mux, registered with the ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      if (req.adr == {1'b0, mcr_pkg::CTRL_STATUS_OFS})
        wb_dat_o <= {24'h00_0000, ctrl_reg};
      else if (req.adr == {1'b0, mcr_pkg::BEEP_CTRL_OFS})
        wb_dat_o <= {30'h0000_0000, tone_sel_reg};
      else if (req.adr == {1'b0, mcr_pkg::IRQ_STATUS_OFS})
        wb_dat_o <= {31'h0000_0000, irq_status_reg};
      else if (req.adr == mcr_pkg::IRQ_ENABLE_OFS)
        wb_dat_o <= {31'h0000_0000, irq_enable_reg};
      else if (req.adr == mcr_pkg::POWER_MODE_OFS)
        wb_dat_o <= {30'h0000_0000, mode_reg};
      else
        wb_dat_o <= 32'h0000_0000;
    end
  end

  // control bits 7..1 written by software; flag bit handled below
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_bits_reg <= mcr_pkg::CTRL_STATUS_RST[7:1];
    else if (wr && !frozen && req.adr == {1'b0, mcr_pkg::CTRL_STATUS_OFS})
      ctrl_bits_reg <= req.dat[7:1];
  end

  // software view of control/status: control bits above the flag
  assign ctrl_reg = {ctrl_bits_reg, ovf_flag_reg};

  // overflow flag; a wrap in the read cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovf_flag_reg <= 1'b0;
    else if (tb_wrap)
      ovf_flag_reg <= 1'b1;
    else if (rd && req.adr == {1'b0, mcr_pkg::CTRL_STATUS_OFS})
      ovf_flag_reg <= 1'b0;
  end

  // beep control register, only the low two bits exist
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tone_sel_reg <= mcr_pkg::TONE_RST;
    else if (wr && !frozen && req.adr == {1'b0, mcr_pkg::BEEP_CTRL_OFS})
      tone_sel_reg <= req.dat[1:0];
  end

  // timebase period lookup for the latched selection
  // period codes
  always_comb
  begin
    case (tb_active_reg)
      2'b00: tb_period = mcr_pkg::TB_PERIOD_0;
      2'b01: tb_period = mcr_pkg::TB_PERIOD_1;
      2'b10: tb_period = mcr_pkg::TB_PERIOD_2;
      default: tb_period = mcr_pkg::TB_PERIOD_3;
    endcase
  end
  assign tb_wrap = counting && (tb_count_reg == tb_period - 18'd1);

  // the counter compares against period-1 and wraps to zero, so one
  // period is exactly the selected number of cycles; the selection is
  // latched only at the wrap, a write mid-period changes nothing now
  // timebase divider; selection sampled only at wrap so periods never shift
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tb_count_reg <= 18'd0;
      tb_active_reg <= 2'b00;
    end
    else if (tb_wrap)
    begin
      tb_count_reg <= 18'd0;
      tb_active_reg <= ctrl_reg[mcr_pkg::TIMEBASE_LSB +: 2];
    end
    else if (counting)
      tb_count_reg <= tb_count_reg + 18'd1;
  end

  // the sticky status copies the overflow event for software that
  // polls the interrupt registers instead of control/status; reading
  // it does not touch the overflow flag
  // sticky interrupt status, write-one clear; set wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_status_reg <= 1'b0;
    else if (tb_wrap)
      irq_status_reg <= 1'b1;
    else if (wr && req.adr == {1'b0, mcr_pkg::IRQ_CLEAR_OFS} && req.dat[0])
      irq_status_reg <= 1'b0;
  end

  // interrupt enable register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_enable_reg <= 1'b0;
    else if (wr && req.adr == mcr_pkg::IRQ_ENABLE_OFS)
      irq_enable_reg <= req.dat[0];
  end

  assign ovf_req = ctrl_reg[mcr_pkg::OVF_FLAG_BIT] && ctrl_reg[mcr_pkg::OVF_IRQ_EN_BIT];
  assign irq_o = ovf_req || (irq_status_reg && irq_enable_reg);

  // mode moves:
  //   run -> active-halt on a halt request with the overflow enable set
  //   run -> full halt on a halt request with the enable clear
  //   run -> wait on a software write to the power mode register
  //   wait and active-halt -> run on the overflow request or a wake
  //   full halt -> run only on the external wake; the timebase is
  //   frozen there, so it could never end the halt anyway
  // power mode tracker; the core reports halt and external wake-ups
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mode_reg <= mcr_pkg::MODE_RUN;
    else
    begin
      case (mode_reg)
        mcr_pkg::MODE_RUN:
        begin
          if (halt_req_i && ctrl_reg[mcr_pkg::OVF_IRQ_EN_BIT])
            mode_reg <= mcr_pkg::MODE_ACTIVE_HALT;
          else if (halt_req_i)
            mode_reg <= mcr_pkg::MODE_HALT;
          else if (wr && req.adr == mcr_pkg::POWER_MODE_OFS && req.dat[0])
            mode_reg <= mcr_pkg::MODE_WAIT;
        end
        mcr_pkg::MODE_WAIT:
        begin
          if (ovf_req || wake_i)
            mode_reg <= mcr_pkg::MODE_RUN;
        end
        mcr_pkg::MODE_ACTIVE_HALT:
        begin
          if (ovf_req || wake_i)
            mode_reg <= mcr_pkg::MODE_RUN;
        end
        default:
        begin
          if (wake_i)
            mode_reg <= mcr_pkg::MODE_RUN;
        end
      endcase
    end
  end
  assign power_mode_o = mode_reg;
  assign wake_o = (mode_reg != mcr_pkg::MODE_RUN) && (mode_reg != mcr_pkg::MODE_HALT) && ovf_req;

  // the prescaler count runs all the time, so a change of divider code
  // takes effect within one count cycle without a restart; the core may
  // see one short gap between enables at the change, never a long one
  // core clock enable: one pulse every 2^(code+1) cycles in slow mode
  // normal or slow rate
  always_comb
  begin
    if (!ctrl_reg[mcr_pkg::SLOW_MODE_BIT])
      core_en_next = 1'b1;
    else
    begin
      case (ctrl_reg[mcr_pkg::SLOW_DIV_LSB +: 2])
        2'b00: core_en_next = (div_count_reg[0] == 1'b1);
        2'b01: core_en_next = (div_count_reg[1:0] == 2'b11);
        2'b10: core_en_next = (div_count_reg[2:0] == 3'b111);
        default: core_en_next = (div_count_reg == 4'hF);
      endcase
    end
  end

  // free running prescaler; independent of timebase and beeper
  // separate counters
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_count_reg <= 4'h0;
      core_en_reg <= 1'b1;
    end
    else
    begin
      div_count_reg <= div_count_reg + 4'h1;
      core_en_reg <= core_en_next;
    end
  end
  assign core_clk_en_o = core_en_reg;

  // clock out: toggles at each core clock enable, gated in halt modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clk_out_reg <= 1'b0;
    else if (frozen || !ctrl_reg[mcr_pkg::CLK_OUT_BIT])
      clk_out_reg <= 1'b0;
    else if (core_en_reg)
      clk_out_reg <= !clk_out_reg;
  end
  assign clock_out_pin_o = clk_out_reg;
  assign clock_out_oe_o = ctrl_reg[mcr_pkg::CLK_OUT_BIT];

  // the tone counter restarts when the tone is off or in full halt, so
  // a tone started from off begins with a full low half; in active-halt it keeps
  // running, software turns it off before the halt if power matters
  // tone half period lookup
  // tone codes
  always_comb
  begin
    case (tone_sel_reg)
      2'b01: tone_half = mcr_pkg::TONE_HALF_1;
      2'b10: tone_half = mcr_pkg::TONE_HALF_2;
      default: tone_half = mcr_pkg::TONE_HALF_3;
    endcase
  end

  // tone generator: square wave, equal high and low halves
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tone_sel_reg == 2'b00 || mode_reg == mcr_pkg::MODE_HALT)
    begin
      tone_count_reg <= 14'd0;
      tone_reg <= 1'b0;
    end
    else if (tone_count_reg >= tone_half - 14'd1)
    begin
      tone_count_reg <= 14'd0;
      tone_reg <= !tone_reg;
    end
    else
      tone_count_reg <= tone_count_reg + 14'd1;
  end
  assign tone_pin_o = tone_reg;
  assign tone_oe_o = (tone_sel_reg != 2'b00);
endmodule

// [mcr_clock_ctrl_chk.sv]
// checker: bus and power-mode assertions at the controller's ports
`timescale 1ns/1ps
module mcr_clock_ctrl_chk (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // mode and pins
  input wire logic [1:0] power_mode_o,
  input wire logic wake_i,
  input wire logic wake_o,
  input wire logic irq_o,
  input wire logic clock_out_pin_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus answer one cycle after the take, for one cycle only
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after take");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // clock-out stands still across active-halt
  a_out_frozen: assert property (
    power_mode_o == 2'h2 && $past(power_mode_o) == 2'h2 && $past(power_mode_o, 2) == 2'h2
      |-> $stable(clock_out_pin_o))
    else $error("clock-out moved in active-halt");
  // full halt ends only by an external wake, never by the timebase
  a_halt_holds: assert property (
    power_mode_o == 2'h3 && !wake_i && !$past(wake_i) |=> power_mode_o == 2'h3)
    else $error("full halt left without wake");
  a_halt_no_wake: assert property (power_mode_o == 2'h3 |-> !wake_o)
    else $error("timebase wake in full halt");
  // a timebase wake request is always an interrupt request
  a_wake_irq: assert property (wake_o |-> irq_o)
    else $error("wake without interrupt");
  a_ahalt_exit: assert property (
    power_mode_o == 2'h2 && wake_o |-> ##[1:4] power_mode_o != 2'h2)
    else $error("active-halt not left on wake");
endmodule
bind mcr_clock_ctrl mcr_clock_ctrl_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .power_mode_o(power_mode_o), .wake_i(wake_i), .wake_o(wake_o), .irq_o(irq_o),
  .clock_out_pin_o(clock_out_pin_o));

// [mcr_core_model.sv]
// core model: issues halt and wake requests, counts core clock enables
`timescale 1ns/1ps
module mcr_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // commands from the bench
  input wire logic halt_cmd_i,
  input wire logic ext_irq_i,
  // from the controller
  input wire logic core_clk_en_i,
  input wire logic [1:0] power_mode_i,
  // to the controller
  output logic halt_req_o,
  output logic wake_o,
  output logic [15:0] en_cnt_o
);
  // a sleeping core runs no code, so halt is issued from run mode only
  always_ff @(posedge clk_i)
    halt_req_o <= !rst_i && halt_cmd_i && power_mode_i == 2'h0;
  // external wake-capable interrupt, registered like a pin synchroniser
  always_ff @(posedge clk_i)
    wake_o <= !rst_i && ext_irq_i;
  // enables seen by the core; the bench measures differences only
  always_ff @(posedge clk_i)
    en_cnt_o <= rst_i ? 16'h0000 : en_cnt_o + 16'(core_clk_en_i);
endmodule

// [mcr_pkg.sv]
// package: register map, field positions, reset values and counts for the clock controller
package mcr_pkg;
  // word-aligned byte offsets on the wishbone bus
  localparam logic [3:0] CTRL_STATUS_OFS = 4'h0;
  localparam logic [3:0] BEEP_CTRL_OFS = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFS = 4'h8;
  localparam logic [3:0] IRQ_CLEAR_OFS = 4'hC;
  localparam logic [4:0] IRQ_ENABLE_OFS = 5'h10;
  localparam logic [4:0] POWER_MODE_OFS = 5'h14;

  // control/status field positions
  localparam int CLK_OUT_BIT = 7;
  localparam int SLOW_DIV_LSB = 5;
  localparam int SLOW_MODE_BIT = 4;
  localparam int TIMEBASE_LSB = 2;
  localparam int OVF_IRQ_EN_BIT = 1;
  localparam int OVF_FLAG_BIT = 0;

  // reset values
  localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
  localparam logic [1:0] TONE_RST = 2'h0;

  // timebase periods in oscillator cycles
  localparam logic [17:0] TB_PERIOD_0 = 18'd16000;
  localparam logic [17:0] TB_PERIOD_1 = 18'd32000;
  localparam logic [17:0] TB_PERIOD_2 = 18'd80000;
  localparam logic [17:0] TB_PERIOD_3 = 18'd200000;

  // tone half periods for an 8 MHz oscillator: 2 kHz, 1 kHz, 500 Hz
  localparam logic [13:0] TONE_HALF_1 = 14'd2000;
  localparam logic [13:0] TONE_HALF_2 = 14'd4000;
  localparam logic [13:0] TONE_HALF_3 = 14'd8000;

  // power modes seen from the core
  typedef enum logic [1:0] {MODE_RUN, MODE_WAIT, MODE_ACTIVE_HALT, MODE_HALT} mcr_mode_t;

  // classic wishbone request bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } mcr_wb_req_t;
endpackage

// [tb_mcr_clock_ctrl.sv]
// testbench: bus tasks and scenarios for the clock controller
`timescale 1ns/1ps
module tb_mcr_clock_ctrl;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mcr_pkg::mcr_wb_req_t req = '0;
  logic [31:0] dat, rdat;
  logic [1:0] mode;
  logic [15:0] en_cnt, e;
  logic ack, hreq, wk, wko, irq, cen, cop, coe, tp, toe, pc;
  logic hcmd = 1'b0;
  logic ext = 1'b0;
  int error_cnt = 0, n_checks = 0, cyc = 0, last = 0, t = 0, n = 0;
  // free-running clock and cycle count
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  mcr_clock_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
    .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel),
    .wb_dat_i(req.dat), .wb_dat_o(dat), .wb_ack_o(ack), .halt_req_i(hreq),
    .wake_i(wk), .power_mode_o(mode), .wake_o(wko), .core_clk_en_o(cen),
    .clock_out_pin_o(cop), .clock_out_oe_o(coe), .tone_pin_o(tp),
    .tone_oe_o(toe), .irq_o(irq));
  mcr_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .halt_cmd_i(hcmd),
    .ext_irq_i(ext), .core_clk_en_i(cen), .power_mode_i(mode),
    .halt_req_o(hreq), .wake_o(wk), .en_cnt_o(en_cnt));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic near(input int d, input int x);
    check({31'h0, d >= x - 1 && d <= x + 1}, 32'h1);
  endtask
  // one classic cycle: request held until ack is sampled
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, 4'h1, {24'h00_0000, d}};
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat;
    req <= '0;
  endtask
  // interval from the previous overflow to this one
  task automatic wait_irq(input int x);
    while (irq !== 1'b1)
      @(posedge clk_i);
    near(cyc - last, x);
    last = cyc;
  endtask
  task automatic tog(input logic p);
    do @(posedge clk_i); while (p === tp);
  endtask
  task automatic halt();
    hcmd <= 1'b1;
    @(posedge clk_i);
    hcmd <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic t_first();
    bus(0, 5'h00, 8'h00);
    check(rdat, 32'h0000_0000);
    bus(0, 5'h18, 8'h00);
    check(rdat, 32'h0000_0000);
    bus(1, 5'h00, 8'h02);
    wait_irq(16000);
    bus(0, 5'h00, 8'h00);
    check(rdat, 32'h0000_0003);
    // plain read clears the flag, so no read-modify-write is used
    bus(0, 5'h00, 8'h00);
    check(rdat, 32'h0000_0002);
    check(irq, 1'b0);
    bus(0, 5'h08, 8'h00);
    check(rdat, 32'h0000_0001);
    bus(1, 5'h0C, 8'h01);
    bus(0, 5'h08, 8'h00);
    check(rdat, 32'h0000_0000);
  endtask
  task automatic t_ahalt();
    bus(1, 5'h00, 8'h86);
    wait_irq(16000);
    bus(0, 5'h00, 8'h00);
    check(coe, 1'b1);
    halt();
    check(mode, 2'h2);
    n = 0;
    pc = cop;
    repeat (64)
    begin
      @(posedge clk_i);
      n += int'(cop !== pc);
      pc = cop;
    end
    check(n, 0);
    wait_irq(32000);
    repeat (6) @(posedge clk_i);
    check(mode, 2'h0);
    bus(0, 5'h00, 8'h00);
  endtask
  task automatic t_slow();
    for (int k = 0; k < 5; k++)
    begin
      bus(1, 5'h00, k < 4 ? {1'b0, 2'(k), 5'h14} : 8'h04);
      e = en_cnt;
      repeat (160) @(posedge clk_i);
      // k of four means normal mode, an enable on every cycle
      near(int'(en_cnt - e), k < 4 ? 160 >> (k + 1) : 160);
    end
  endtask
  task automatic t_tone();
    for (int c = 1; c < 4; c++)
    begin
      bus(1, 5'h04, 8'(c));
      tog(tp);
      t = cyc;
      tog(tp);
      near(cyc - t, 1000 << c);
    end
    bus(1, 5'h04, 8'h00);
    check(toe, 1'b0);
  endtask
  task automatic t_wait();
    bus(1, 5'h14, 8'h01);
    bus(0, 5'h14, 8'h00);
    check(rdat, 32'h0000_0001);
    ext <= 1'b1;
    @(posedge clk_i);
    ext <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(mode, 2'h0);
  endtask
  task automatic t_halt();
    halt();
    check(mode, 2'h3);
    repeat (3000) @(posedge clk_i);
    check(mode, 2'h3);
    ext <= 1'b1;
    @(posedge clk_i);
    ext <= 1'b0;
    repeat (6) @(posedge clk_i);
    check(mode, 2'h0);
  endtask
  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence after a 12-cycle reset
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    last = cyc;
    t_first();
    t_ahalt();
    t_slow();
    t_tone();
    t_wait();
    t_halt();
    close_out();
  end
  // watchdog well past the expected span of the run
  initial
  begin
    repeat (110000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end
endmodule
